// File: logic/wdl_pkg.sv
// package: watchdog register map, fields, reset values and timing constants
package wdl_pkg;
	localparam int          ADDR_W            = 4;
	localparam logic [3:0]  OFS_CONTROL_REGISTER_ZERO         = 4'h0;
	localparam logic [3:0]  OFS_WDT_CTRL      = 4'h4;
	localparam logic [3:0]  OFS_WDT_COUNT     = 4'h8;
	localparam logic [3:0]  OFS_STATUS        = 4'hC;
	// control_register_zero fields
	localparam int          CONTROL_REGISTER_ZERO_LOWPWR_BIT  = 0;
	// watchdog_control_register fields
	localparam int          SUP_LO_BIT        = 0;
	localparam int          SUP_HI_BIT        = 1;
	localparam int          RC_EN_LO_BIT      = 2;
	localparam int          RC_EN_HI_BIT      = 3;
	localparam int          RATE_LSB          = 5;
	localparam int          RATE_MSB          = 7;
	// status fields
	localparam int          ST_TIMEOUT_BIT    = 0;
	localparam int          ST_RC_RUN_BIT     = 1;
	localparam int          ST_SUP_REG_BIT    = 2;
	localparam int          ST_LOWPWR_BIT     = 3;
	// reset values and field codes
	localparam logic [7:0]  CONTROL_REGISTER_ZERO_RST         = 8'h00;
	localparam logic [7:0]  WDT_CTRL_RST_RC   = 8'hE9;
	localparam logic [7:0]  WDT_CTRL_RST_OFF  = 8'hE5;
	localparam logic [1:0]  CODE_SUP_REG      = 2'h2;
	localparam logic [1:0]  CODE_RC_OFF       = 2'h1;
	// counter geometry
	localparam int          CNT_W             = 15;
	localparam int          RATE_BASE         = 8;
	localparam int          VIEW_LSB          = 4;
	localparam int          VIEW_MSB          = 11;
	localparam int          INSTR_DIV         = 4;
	// rc period 65 us, 2^15 periods give about 2.13 s
	localparam real         RC_PERIOD_US      = 65.0;
	localparam real         RC_TIMEOUT_S      = RC_PERIOD_US * 32768.0 / 1.0e6;
	typedef enum logic [1:0] {
		WDL_SRC_RC,
		WDL_SRC_XTAL,
		WDL_SRC_INSTR
	} wdl_src_t;
endpackage

// File: logic/wdl_watchdog.sv
// watchdog with slow clock source control and avalon-mm register slave
// Behaviour
// - low-power select bit: 0 quick start, 1 reduced current
// - power-on reset clears the low-power select bit
// - crystal keeps running in both modes; low-power only lengthens start-up
// - rc oscillator keeps running in power-down while a user needs it
// - counter clock chosen from rc, crystal or instruction clock (sys/4)
// - disabled watchdog still counts, reads and clears, but never resets
// - count register is read-only; writes ignored
// - supply select picks watchdog power; defaults to charge pump
// - rc disabled by its enable bits stops even if selected
// - rc source at largest division times out near 2.13 s
// - instruction clock source stops counting in power-down
// - overflow in normal operation gives chip reset and sets timeout flag
// - overflow in power-down gives warm reset of pc and sp
// - counter cleared by external reset low, clear instruction, or halt
// - option enables single clear or paired clear, never both
// - single-clear mode: each single clear instruction clears counter
// - paired-clear mode: clear only after both halves executed
// - supply 10 regulator; 01, 00, 11 charge pump
// - rc enable 01 disables; 10, 00, 11 enable
// - rate code selects period of 2^8..2^15 watchdog clocks
// - count register returns counter bits 4 to 11
//
// Chosen here: the register addresses and register access over Avalon-MM.
module wdl_watchdog
	import wdl_pkg::*;
(
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic                 por,
	input  wire logic [ADDR_W-1:0]    avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic [31:0]               avs_readdata,
	output logic                      avs_waitrequest,
	input  wire logic                 rc_clk_in,
	input  wire logic                 xtal_clk_in,
	input  wire logic                 external_reset_pin_n,
	input  wire logic                 single_watchdog_clear,
	input  wire logic                 paired_clear_first,
	input  wire logic                 paired_clear_second,
	input  wire logic                 halt_exec,
	input  wire logic                 power_down,
	input  wire logic                 cfg_wdt_enable,
	input  wire logic                 cfg_paired_clear,
	input  wire wdl_pkg::wdl_src_t    cfg_clk_src,
	input  wire logic                 rc_needed_other,
	output logic                      chip_reset_req,
	output logic                      warm_reset_req,
	output logic                      rc_osc_run,
	output logic                      crystal_low_power_select,
	output logic                      supply_from_regulator
);
	import wdl_pkg::*;

	logic [7:0]       control_register_zero_r;
	logic [7:0]       wctrl_r;
	logic             timeout_r;
	logic [CNT_W-1:0] cnt_r;
	logic [1:0]       rc_sync_r;
	logic [1:0]       xt_sync_r;
	logic [1:0]       rs_sync_r;
	logic             rc_prev_r;
	logic             xt_prev_r;
	logic [1:0]       div_r;
	logic             half1_r;
	logic             half2_r;
	logic             ack_r;
	logic             tick;
	logic             sw_clear;
	logic             do_clear;
	logic             ovf;
	logic             rc_on;
	logic             bus_req;
	logic [31:0]      rd_nxt;

	// rc enable decode, used for oscillator gate and status
	function automatic logic rc_enabled(input logic [1:0] code);
		return code != CODE_RC_OFF;
	endfunction

	// rate code to overflow bit index
	function automatic logic [3:0] rate_bit(input logic [2:0] code);
		return 4'(RATE_BASE - 1) + 4'(code);
	endfunction

	assign bus_req = (avs_read | avs_write) & ~ack_r;

	// one wait state per access, then release
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= bus_req;
		end
	end

	// waitrequest from its own flop, mirrors ~ack_r
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~bus_req;
		end
	end

	// low-power bit, cleared by rst and by power-on
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			control_register_zero_r <= CONTROL_REGISTER_ZERO_RST;
		end else if (por) begin
			control_register_zero_r <= CONTROL_REGISTER_ZERO_RST;
		end else if (avs_write && ack_r && avs_address == OFS_CONTROL_REGISTER_ZERO && avs_byteenable[0]) begin
			control_register_zero_r <= avs_writedata[7:0];
		end
	end

	// supply defaults to charge pump; rc reset code follows options
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wctrl_r <= WDT_CTRL_RST_RC;
		end else if (por) begin
			wctrl_r <= (cfg_wdt_enable && cfg_clk_src == WDL_SRC_RC) ?
				WDT_CTRL_RST_RC : WDT_CTRL_RST_OFF;
		end else if (avs_write && ack_r && avs_address == OFS_WDT_CTRL && avs_byteenable[0]) begin
			wctrl_r <= avs_writedata[7:0] & 8'hEF;
		end
	end

	// rc runs when enabled; enable bits override any user
	assign rc_on = rc_enabled(wctrl_r[RC_EN_HI_BIT:RC_EN_LO_BIT]);

	// slow clocks are asynchronous: two flops before edge detection
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rc_sync_r <= 2'h0;
			xt_sync_r <= 2'h0;
			rs_sync_r <= 2'h3;
			rc_prev_r <= 1'b0;
			xt_prev_r <= 1'b0;
		end else begin
			rc_sync_r <= {rc_sync_r[0], rc_clk_in};
			xt_sync_r <= {xt_sync_r[0], xtal_clk_in};
			rs_sync_r <= {rs_sync_r[0], external_reset_pin_n};
			rc_prev_r <= rc_sync_r[1];
			xt_prev_r <= xt_sync_r[1];
		end
	end

	// instruction clock prescaler, sys/4
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_r <= 2'h0;
		end else begin
			div_r <= div_r + 2'h1;
		end
	end

	// source select; instruction clock halts in power-down
	always_comb begin
		unique case (cfg_clk_src)
			// gate after the sync: raw pin feeds only the first flop
			WDL_SRC_RC:    tick = rc_sync_r[1] & ~rc_prev_r & rc_on;
			WDL_SRC_XTAL:  tick = xt_sync_r[1] & ~xt_prev_r;
			WDL_SRC_INSTR: tick = (div_r == 2'(INSTR_DIV - 1)) & ~power_down;
			default:       tick = 1'b0;
		endcase
	end

	assign sw_clear = cfg_paired_clear ?
		((half1_r | paired_clear_first) & (half2_r | paired_clear_second)) :
		single_watchdog_clear;

	// pin low, software clear or halt
	assign do_clear = ~rs_sync_r[1] | sw_clear | halt_exec;

	// overflow when selected bit would carry
	assign ovf = tick & (&cnt_r[rate_bit(wctrl_r[RATE_MSB:RATE_LSB]) -: 1])
		& (cnt_r[rate_bit(wctrl_r[RATE_MSB:RATE_LSB]) -: 1] != 1'b0)
		& ((cnt_r & ((CNT_W'(1) << (rate_bit(wctrl_r[RATE_MSB:RATE_LSB]) + 4'h1))
			- CNT_W'(1))) == ((CNT_W'(1) << (rate_bit(wctrl_r[RATE_MSB:RATE_LSB]) + 4'h1))
			- CNT_W'(1)));

	// halves in any order, forgotten after clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			half1_r <= 1'b0;
			half2_r <= 1'b0;
		end else if (do_clear || !cfg_paired_clear) begin
			half1_r <= 1'b0;
			half2_r <= 1'b0;
		end else begin
			half1_r <= half1_r | paired_clear_first;
			half2_r <= half2_r | paired_clear_second;
		end
	end

	// counts regardless of enable; wraps on overflow
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
		end else if (do_clear || ovf) begin
			cnt_r <= '0;
		end else if (tick) begin
			cnt_r <= cnt_r + CNT_W'(1);
		end
	end

	// reset kind follows power state; disabled gives none
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			chip_reset_req <= 1'b0;
			warm_reset_req <= 1'b0;
		end else begin
			chip_reset_req <= ovf & cfg_wdt_enable & ~power_down;
			warm_reset_req <= ovf & cfg_wdt_enable & power_down;
		end
	end

	// timeout flag: set wins over a write-one clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			timeout_r <= 1'b0;
		end else if (ovf && cfg_wdt_enable && !power_down) begin
			timeout_r <= 1'b1;
		end else if (avs_write && ack_r && avs_address == OFS_STATUS && avs_byteenable[0]
			&& avs_writedata[ST_TIMEOUT_BIT]) begin
			timeout_r <= 1'b0;
		end
	end

	// mode and supply go straight out from flops
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			crystal_low_power_select <= 1'b0;
			supply_from_regulator    <= 1'b0;
			rc_osc_run               <= 1'b1;
		end else begin
			crystal_low_power_select <= control_register_zero_r[CONTROL_REGISTER_ZERO_LOWPWR_BIT];
			supply_from_regulator    <= wctrl_r[SUP_HI_BIT:SUP_LO_BIT] == CODE_SUP_REG;
			rc_osc_run               <= rc_on;
		end
	end

	// count view is read-only, bits 4..11
	always_comb begin
		rd_nxt = 32'h0000_0000;
		unique case (avs_address)
			OFS_CONTROL_REGISTER_ZERO:     rd_nxt[7:0] = control_register_zero_r;
			OFS_WDT_CTRL:  rd_nxt[7:0] = wctrl_r;
			OFS_WDT_COUNT: rd_nxt[7:0] = cnt_r[VIEW_MSB:VIEW_LSB];
			OFS_STATUS: begin
				rd_nxt[ST_TIMEOUT_BIT] = timeout_r;
				rd_nxt[ST_RC_RUN_BIT]  = rc_on;
				rd_nxt[ST_SUP_REG_BIT] = supply_from_regulator;
				rd_nxt[ST_LOWPWR_BIT]  = control_register_zero_r[CONTROL_REGISTER_ZERO_LOWPWR_BIT];
			end
			default:       rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !ack_r) begin
			avs_readdata <= rd_nxt;
		end
	end

	// clear sources empty the counter next edge
	property p_clear_empties;
		@(posedge sys_clk) disable iff (rst)
		do_clear |=> cnt_r == '0;
	endproperty
	a_clear_empties: assert property (p_clear_empties) else $error("counter not cleared");

	property p_disabled_no_reset;
		@(posedge sys_clk) disable iff (rst)
		!cfg_wdt_enable |=> !chip_reset_req && !warm_reset_req;
	endproperty
	a_disabled_no_reset: assert property (p_disabled_no_reset) else $error("reset while disabled");

	property p_chip_reset;
		@(posedge sys_clk) disable iff (rst)
		ovf && cfg_wdt_enable && !power_down |=> chip_reset_req && timeout_r;
	endproperty
	a_chip_reset: assert property (p_chip_reset) else $error("missing chip reset");

	property p_warm_reset;
		@(posedge sys_clk) disable iff (rst)
		ovf && cfg_wdt_enable && power_down |=> warm_reset_req && !chip_reset_req;
	endproperty
	a_warm_reset: assert property (p_warm_reset) else $error("missing warm reset");

	property p_instr_halts;
		@(posedge sys_clk) disable iff (rst)
		cfg_clk_src == WDL_SRC_INSTR && power_down && !do_clear |=> $stable(cnt_r);
	endproperty
	a_instr_halts: assert property (p_instr_halts) else $error("count moved in power-down");

	property p_rc_off;
		@(posedge sys_clk) disable iff (rst)
		wctrl_r[RC_EN_HI_BIT:RC_EN_LO_BIT] == CODE_RC_OFF |=> !rc_osc_run;
	endproperty
	a_rc_off: assert property (p_rc_off) else $error("rc running while off");

	property p_single_only;
		@(posedge sys_clk) disable iff (rst)
		!cfg_paired_clear && single_watchdog_clear |=> cnt_r == '0;
	endproperty
	a_single_only: assert property (p_single_only) else $error("single clear failed");

	property p_half_ignored;
		@(posedge sys_clk) disable iff (rst)
		cfg_paired_clear && paired_clear_first && !half2_r && !paired_clear_second
			&& !halt_exec && rs_sync_r[1] && tick && !ovf |=> cnt_r != '0;
	endproperty
	a_half_ignored: assert property (p_half_ignored) else $error("half pair cleared");

	property p_supply;
		@(posedge sys_clk) disable iff (rst)
		wctrl_r[SUP_HI_BIT:SUP_LO_BIT] != CODE_SUP_REG |=> !supply_from_regulator;
	endproperty
	a_supply: assert property (p_supply) else $error("regulator wrongly chosen");

	property p_rc_kept;
		@(posedge sys_clk) disable iff (rst)
		power_down && rc_needed_other && rc_on |=> rc_osc_run;
	endproperty
	a_rc_kept: assert property (p_rc_kept) else $error("rc stopped while needed");

	property p_count_ro;
		@(posedge sys_clk) disable iff (rst)
		avs_write && ack_r && avs_address == OFS_WDT_COUNT && !do_clear && !tick
			|=> $stable(cnt_r);
	endproperty
	a_count_ro: assert property (p_count_ro) else $error("count register took a write");

	c_chip_reset: cover property (@(posedge sys_clk) disable iff (rst) chip_reset_req);
	c_warm_reset: cover property (@(posedge sys_clk) disable iff (rst) warm_reset_req);
	c_pair_clear: cover property (@(posedge sys_clk) disable iff (rst)
		cfg_paired_clear && half1_r && paired_clear_second);
endmodule

// File: test/wdl_core_model.sv
// core model: one-cycle clear and halt strobes from the processor
module wdl_core_model (
	input  wire logic sys_clk,
	output logic      single_watchdog_clear,
	output logic      paired_clear_first,
	output logic      paired_clear_second,
	output logic      halt_exec
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] stb = 4'h0;
	assign single_watchdog_clear = stb[0];
	assign paired_clear_first    = stb[1];
	assign paired_clear_second   = stb[2];
	assign halt_exec             = stb[3];
	task automatic pulse(input logic [3:0] k);
		@(posedge sys_clk);
		stb <= k;
		@(posedge sys_clk);
		stb <= 4'h0;
	endtask
	task automatic issue(input logic [3:0] k);
		logic sw;
		sw = 1'($urandom_range(1, 0));
		if (k[1] && k[2]) begin
			pulse(sw ? 4'h4 : 4'h2);
			// gap varies: prompt or slow core
			repeat ($urandom_range(6, 0)) @(posedge sys_clk);
			pulse(sw ? 4'h2 : 4'h4);
		end else begin
			pulse(k);
		end
	endtask
endmodule

// File: test/tb_top.sv
// testbench: watchdog registers, clears, overflow and power-down
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import wdl_pkg::*;
	localparam int RC_CYC = 6;
	localparam int XT_CYC = 10;
	localparam int GAP = 336;
	localparam logic [31:0] GAP_VIEW = 32'((GAP / INSTR_DIV) >> VIEW_LSB);
	logic        sys_clk = 1'h0, rst = 1'h1, por = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
	logic        rc_clk_in = 1'h0, xtal_clk_in = 1'h0, external_reset_pin_n = 1'h1;
	logic        power_down = 1'h0, cfg_wdt_enable = 1'h1, cfg_paired_clear = 1'h0;
	logic        rc_needed_other = 1'h0, avs_waitrequest, chip_reset_req, warm_reset_req;
	logic        rc_osc_run, crystal_low_power_select, supply_from_regulator;
	logic        single_watchdog_clear, paired_clear_first, paired_clear_second, halt_exec;
	logic [3:0]  avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	wdl_src_t    cfg_clk_src = WDL_SRC_INSTR;
	int          failures = 0, tests_run = 0, cyc = 0;
	always #2.5 sys_clk = ~sys_clk;
	always #15 rc_clk_in = ~rc_clk_in;
	always #25 xtal_clk_in = ~xtal_clk_in;
	wdl_watchdog dut (
		.sys_clk, .rst, .por, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .rc_clk_in, .xtal_clk_in,
		.external_reset_pin_n, .single_watchdog_clear, .paired_clear_first,
		.paired_clear_second, .halt_exec, .power_down, .cfg_wdt_enable, .cfg_paired_clear,
		.cfg_clk_src, .rc_needed_other, .chip_reset_req, .warm_reset_req, .rc_osc_run,
		.crystal_low_power_select, .supply_from_regulator
	);
	wdl_core_model core (
		.sys_clk, .single_watchdog_clear, .paired_clear_first, .paired_clear_second,
		.halt_exec
	);
	task automatic conclude();
		if (failures == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// hang guard: whole run needs well under this
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_pin(input logic g, input logic e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask
	// sync stages and tick phase blur the exact cycle
	task automatic chk_t(input int g, input int e);
		tests_run++;
		if (g < e - 16 || g > e + 16) begin
			failures++;
			$display("wrong value at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= ~w;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
		q = avs_readdata;
		avs_write <= 1'h0;
		avs_read  <= 1'h0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(q, e);
	endtask
	function automatic int per(wdl_src_t s, logic [2:0] r);
		return (1 << (RATE_BASE + r)) *
			(s == WDL_SRC_INSTR ? INSTR_DIV : s == WDL_SRC_RC ? RC_CYC : XT_CYC);
	endfunction
	// case bits: 0 single, 1 first, 2 second, 3 halt, 4 pin, 5 paired mode, 6 clears
	task automatic clr_case(input logic [6:0] c);
		cfg_paired_clear <= c[5];
		core.issue(4'h8);
		repeat (GAP) @(posedge sys_clk);
		if (c[4]) begin
			external_reset_pin_n <= 1'h0;
			repeat (3) @(posedge sys_clk);
			external_reset_pin_n <= 1'h1;
		end else begin
			core.issue(c[3:0]);
		end
		bus(1'h1, OFS_WDT_COUNT, $urandom);
		rchk(OFS_WDT_COUNT, c[6] ? 32'h0 : GAP_VIEW);
	endtask
	// pe: {enable, power down}; ek: {warm, chip}
	task automatic ovf(input wdl_src_t s, input logic [7:0] ctl, input logic [1:0] pe,
			input logic [1:0] ek);
		int t0;
		int p;
		logic [1:0] k;
		p = per(s, ctl[7:5]);
		k = 2'h0;
		cfg_clk_src    <= s;
		power_down     <= pe[0];
		cfg_wdt_enable <= pe[1];
		core.issue(4'h8);
		t0 = cyc;
		bus(1'h1, OFS_WDT_CTRL, {24'h0, ctl});
		while (k == 2'h0 && cyc - t0 < p + 40) begin
			@(posedge sys_clk);
			k = {warm_reset_req === 1'h1, chip_reset_req === 1'h1};
		end
		chk({30'h0, k}, {30'h0, ek});
		if (ek != 2'h0) chk_t(cyc - t0, p);
	endtask
	initial begin
		logic [6:0] cases [8] = '{7'h41, 7'h21, 7'h22, 7'h24, 7'h66, 7'h06, 7'h48, 7'h50};
		logic [2:0] r;
		void'($urandom(29));
		repeat (5) @(posedge sys_clk);
		rst             <= 1'h0;
		rc_needed_other <= 1'($urandom_range(1, 0));
		rchk(OFS_CONTROL_REGISTER_ZERO, 32'h0);
		rchk(OFS_WDT_CTRL, {24'h0, WDT_CTRL_RST_RC});
		rchk(OFS_STATUS, 32'h2);
		rchk(4'h2, 32'h0);
		bus(1'h1, OFS_CONTROL_REGISTER_ZERO, 32'h1);
		rchk(OFS_STATUS, 32'hA);
		chk_pin(crystal_low_power_select, 1'h1);
		for (int i = 0; i < 2; i++) begin
			cfg_clk_src <= i ? WDL_SRC_RC : WDL_SRC_INSTR;
			@(posedge sys_clk) por <= 1'h1;
			@(posedge sys_clk) por <= 1'h0;
			rchk(OFS_WDT_CTRL, {24'h0, i ? WDT_CTRL_RST_RC : WDT_CTRL_RST_OFF});
			chk_pin(crystal_low_power_select, 1'h0);
		end
		cfg_clk_src <= WDL_SRC_RC;
		for (int c = 0; c < 4; c++) begin
			r = 3'($urandom);
			power_down      <= c[0];
			rc_needed_other <= c[1];
			bus(1'h1, OFS_WDT_CTRL, {24'h0, r, 1'h1, c[1:0], c[1:0]});
			rchk(OFS_WDT_CTRL, {24'h0, r, 1'h0, c[1:0], c[1:0]});
			chk_pin(supply_from_regulator, c == 2);
			chk_pin(rc_osc_run, c != 1);
		end
		power_down  <= 1'h0;
		cfg_clk_src <= WDL_SRC_INSTR;
		bus(1'h1, OFS_WDT_CTRL, 32'hE9);
		for (int i = 0; i < 8; i++) clr_case(cases[i]);
		r = 3'($urandom_range(2, 0));
		ovf(WDL_SRC_INSTR, {r, 5'h09}, 2'h2, 2'h1);
		rchk(OFS_STATUS, 32'h3);
		bus(1'h1, OFS_STATUS, 32'h1);
		rchk(OFS_STATUS, 32'h2);
		ovf(WDL_SRC_XTAL, 8'h09, 2'h2, 2'h1);
		ovf(WDL_SRC_RC, 8'h09, 2'h3, 2'h2);
		ovf(WDL_SRC_INSTR, 8'h09, 2'h3, 2'h0);
		ovf(WDL_SRC_RC, 8'h09, 2'h0, 2'h0);
		ovf(WDL_SRC_RC, 8'h05, 2'h2, 2'h0);
		conclude();
	end
endmodule
